// >>> core/lotu_line_output.sv
// line output source select with exposure-triggered timer and debounce
// assumes cfg is static or changed by software from the clk domain;
// exposure and frame arrive asynchronously and are synchronised here
`timescale 1ns/1ps
module lotu_line_output #(
    parameter int TIME_W = lotu_pkg::LOTU_TIME_W
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // configuration
    input  wire lotu_pkg::lotu_cfg_type cfg,
    // camera signals, asynchronous
    input  wire logic                  exposure_in,
    input  wire logic                  frame_in,
    // outputs
    output logic                       line_out,
    output logic                       timer_out
);
    import lotu_pkg::*;

    // the longest delay or duration needs the package width of count
    if (TIME_W < LOTU_TIME_W) begin : g_time_w_check
        $error("TIME_W too small for 60e6 us");
    end

    typedef enum logic [1:0] {LOTU_IDLE, LOTU_DELAY, LOTU_ACTIVE} lotu_state_type;

    logic [1:0]            exp_sync_r;
    logic [1:0]            frm_sync_r;
    logic [LOTU_PRE_W-1:0] pre_r;
    logic                  us_tick;
    logic                  exp_deb_r;
    logic                  exp_prev_r;
    logic                  frm_deb_r;
    logic [LOTU_DBT_W-1:0] exp_cnt_r;
    logic [LOTU_DBT_W-1:0] frm_cnt_r;
    logic                  trig;
    lotu_state_type        state_r;
    logic [TIME_W-1:0]     tcnt_r;
    logic                  sel;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_sync_r <= 2'h0;
            frm_sync_r <= 2'h0;
        end else begin
            exp_sync_r <= {exp_sync_r[0], exposure_in};
            frm_sync_r <= {frm_sync_r[0], frame_in};
        end
    end

    // microsecond prescaler shared by debounce and timer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_r <= '0;
        end else if (pre_r == LOTU_PRE_W'(LOTU_US_CYCLES - 1)) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end
    assign us_tick = (pre_r == LOTU_PRE_W'(LOTU_US_CYCLES - 1));

    // debounce filter
    // a change must persist debounce_us microsecond ticks, so more than debounce_us-1 and up to debounce_us us; 0 passes at once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_deb_r <= 1'b0;
            exp_cnt_r <= '0;
        end else if (exp_sync_r[1] == exp_deb_r) begin
            exp_cnt_r <= '0;
        end else if (exp_cnt_r >= cfg.debounce_us) begin
            exp_deb_r <= exp_sync_r[1];
            exp_cnt_r <= '0;
        end else if (us_tick) begin
            exp_cnt_r <= exp_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frm_deb_r <= 1'b0;
            frm_cnt_r <= '0;
        end else if (frm_sync_r[1] == frm_deb_r) begin
            frm_cnt_r <= '0;
        end else if (frm_cnt_r >= cfg.debounce_us) begin
            frm_deb_r <= frm_sync_r[1];
            frm_cnt_r <= '0;
        end else if (us_tick) begin
            frm_cnt_r <= frm_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_prev_r <= 1'b0;
        end else begin
            exp_prev_r <= exp_deb_r;
        end
    end

    always_comb begin
        trig = 1'b0;
        case (cfg.activation)
            LOTU_ACT_FALL: trig = exp_prev_r & ~exp_deb_r;
            LOTU_ACT_RISE: trig = ~exp_prev_r & exp_deb_r;
            LOTU_ACT_LOW:  trig = ~exp_deb_r;
            LOTU_ACT_HIGH: trig = exp_deb_r;
            default:       trig = 1'b0;
        endcase
        trig = trig & cfg.trig_enable;
    end

    // delay then duration
    // retriggers while busy are ignored; level modes rearm after each pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r   <= LOTU_IDLE;
            tcnt_r    <= '0;
            timer_out <= 1'b0;
        end else begin
            case (state_r)
                LOTU_IDLE: begin
                    timer_out <= 1'b0;
                    tcnt_r    <= '0;
                    if (trig) begin
                        state_r <= LOTU_DELAY;
                    end
                end
                LOTU_DELAY: begin
                    if (tcnt_r >= TIME_W'(cfg.delay_us)) begin
                        tcnt_r <= '0;
                        if (cfg.duration_us == '0) begin
                            state_r <= LOTU_IDLE;
                        end else begin
                            state_r   <= LOTU_ACTIVE;
                            timer_out <= 1'b1;
                        end
                    end else if (us_tick) begin
                        tcnt_r <= tcnt_r + 1'b1;
                    end
                end
                LOTU_ACTIVE: begin
                    if (tcnt_r >= TIME_W'(cfg.duration_us)) begin
                        tcnt_r    <= '0;
                        timer_out <= 1'b0;
                        state_r   <= LOTU_IDLE;
                    end else if (us_tick) begin
                        tcnt_r <= tcnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r   <= LOTU_IDLE;
                    timer_out <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        case (cfg.src)
            LOTU_SRC_EXPOSURE: sel = exp_deb_r;
            LOTU_SRC_FRAME:    sel = frm_deb_r;
            LOTU_SRC_USER:     sel = cfg.user_value;
            LOTU_SRC_TIMER:    sel = timer_out;
            default:           sel = 1'b0;
        endcase
    end

    // inversion after select, off held low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_out <= LOTU_LINE_RST;
        end else if (cfg.src == LOTU_SRC_OFF) begin
            line_out <= 1'b0;
        end else begin
            line_out <= sel ^ cfg.invert;
        end
    end

    a_user_level: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && $past(cfg.src) == LOTU_SRC_USER && $past(cfg.invert) == 1'b0)
        |-> line_out == $past(cfg.user_value))
        else $error("user value not driven");

    a_invert_path: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && $past(cfg.src) == LOTU_SRC_TIMER)
        |-> line_out == ($past(timer_out) ^ $past(cfg.invert)))
        else $error("timer path inversion wrong");

    a_off_low: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(cfg.src) == LOTU_SRC_OFF) |-> !line_out)
        else $error("disabled line not low");

    a_trig_off: assert property (@(posedge clk) disable iff (!reset_n)
        (!cfg.trig_enable && state_r == LOTU_IDLE) |=> state_r == LOTU_IDLE)
        else $error("timer started while disabled");

    a_rise_start: assert property (@(posedge clk) disable iff (!reset_n)
        (cfg.trig_enable && cfg.activation == LOTU_ACT_RISE && state_r == LOTU_IDLE
         && exp_deb_r && !exp_prev_r) |=> state_r == LOTU_DELAY)
        else $error("rising edge missed");

    a_delay_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == LOTU_DELAY) |-> !timer_out)
        else $error("timer active during delay");

    a_dur_bound: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == LOTU_ACTIVE) |-> tcnt_r <= TIME_W'(cfg.duration_us))
        else $error("duration overrun");

    a_pulse_order: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(timer_out) |-> $past(state_r) == LOTU_DELAY)
        else $error("timer rose without delay");

    a_deb_stable: assert property (@(posedge clk) disable iff (!reset_n)
        (exp_deb_r != $past(exp_deb_r)) |-> $past(exp_sync_r[1]) == exp_deb_r)
        else $error("debounced value not from input");
endmodule

// >>> core/lotu_pkg.sv
// package for the line output and timer unit: codes, reset values, timing
// assumes a 100 MHz core clock
package lotu_pkg;
    localparam int          LOTU_CLK_MHZ       = 100;
    localparam int          LOTU_US_CYCLES     = LOTU_CLK_MHZ * 1;
    localparam int          LOTU_TIME_MAX_US   = 60000000;
    localparam int          LOTU_TIME_W        = 26;
    localparam int          LOTU_PRE_W         = 7;
    localparam int          LOTU_DBT_W         = 16;

    localparam logic [2:0]  LOTU_SRC_OFF       = 3'h0;
    localparam logic [2:0]  LOTU_SRC_EXPOSURE  = 3'h1;
    localparam logic [2:0]  LOTU_SRC_FRAME     = 3'h2;
    localparam logic [2:0]  LOTU_SRC_USER      = 3'h5;
    localparam logic [2:0]  LOTU_SRC_TIMER     = 3'h7;

    localparam logic [1:0]  LOTU_ACT_FALL      = 2'h0;
    localparam logic [1:0]  LOTU_ACT_RISE      = 2'h1;
    localparam logic [1:0]  LOTU_ACT_LOW       = 2'h2;
    localparam logic [1:0]  LOTU_ACT_HIGH      = 2'h3;

    localparam logic        LOTU_LINE_RST      = 1'b0;

    typedef struct packed {
        logic [2:0]              src;
        logic                    invert;
        logic                    user_value;
        logic                    trig_enable;
        logic [1:0]              activation;
        logic [LOTU_TIME_W-1:0]  delay_us;
        logic [LOTU_TIME_W-1:0]  duration_us;
        logic [LOTU_DBT_W-1:0]   debounce_us;
    } lotu_cfg_type;
endpackage

// >>> tb/lotu_cam_model.sv
// sensor side model: drives exposure and frame levels on request
// assumes the bench sets the requests; lines change off the core edge
`timescale 1ns/1ps
module lotu_cam_model (
    // clock
    input  wire logic clk,
    // requests from the bench
    input  wire logic exp_cmd,
    input  wire logic frm_cmd,
    // camera signals
    output logic      exposure_in,
    output logic      frame_in
);
    logic             exp_hold;
    logic             frm_hold;

    // requests taken on the rising edge, so no race with the bench's falling-edge drive
    always_ff @(posedge clk) begin
        exp_hold <= exp_cmd;
        frm_hold <= frm_cmd;
    end

    // launched mid-cycle so the unit's synchronisers see a real async change
    always_ff @(negedge clk) begin
        exposure_in <= exp_hold;
        frame_in    <= frm_hold;
    end
endmodule

// >>> tb/line_output_timer_unit_tb.sv
// bench for the line output and timer unit
// assumes lotu_pkg compiled first; design asserts its own rules
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module line_output_timer_unit_tb;
    import lotu_pkg::*;
    logic         clk, reset_n, exp_cmd, frm_cmd, exposure_in, frame_in;
    logic         line_out, timer_out, prev, hi;
    lotu_cfg_type cfg;
    int           num_errors = 0;
    int           check_count = 0;
    int           pulses, width, first, lag;
    // row: src[7:5] invert[4] user[3] exposure[2] frame[1] expected line[0]
    // unlisted source code 3 drives low before inversion
    logic [7:0]   rows [13] = '{8'h0e, 8'h1e, 8'h25, 8'h34, 8'h22, 8'h43,
                                8'h52, 8'h44, 8'ha6, 8'ha9, 8'hb8, 8'h71, 8'hf5};

    lotu_cam_model cam (.clk(clk), .exp_cmd(exp_cmd), .frm_cmd(frm_cmd),
                        .exposure_in(exposure_in), .frame_in(frame_in));
    lotu_line_output uut (.clk(clk), .reset_n(reset_n), .cfg(cfg),
                          .exposure_in(exposure_in), .frame_in(frame_in),
                          .line_out(line_out), .timer_out(timer_out));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // settle with the trigger idle, flip exposure, then watch the timer
    task automatic timer_case(input logic [1:0] a, input logic t, input logic s, input int want);
        cfg.src = LOTU_SRC_TIMER;
        cfg.invert = 1'b0;
        cfg.trig_enable = t;
        cfg.activation = a;
        exp_cmd = s;
        repeat (500) @(negedge clk);
        exp_cmd = ~s;
        pulses = 0;
        width = 0;
        first = 0;
        lag = 0;
        prev = timer_out;
        for (int i = 0; i < 1200; i++) begin
            @(negedge clk);
            if (timer_out === 1'b1 && prev !== 1'b1) begin
                pulses++;
                if (pulses == 1) first = i;
            end
            if (pulses == 1 && timer_out === 1'b1) width++;
            if (line_out !== prev) lag++;
            prev = timer_out;
        end
        `CHK("pulse count", want, (pulses > 1) ? 2 : pulses)
        `CHK("line follows timer", 0, lag)
        if (pulses > 0) begin
            `CHK("pulse width", 1'b1, 1'(width >= 100 && width <= 210))
            `CHK("delay span", 1'b1, 1'(first >= 4 && first <= 220))
        end
    endtask

    initial begin
        cfg = '0;
        cfg.src = LOTU_SRC_USER;
        cfg.user_value = 1'b1;
        cfg.invert = 1'b1;
        cfg.delay_us = 26'h1;
        cfg.duration_us = 26'h2;
        reset_n = 1'b0;
        exp_cmd = 1'b0;
        frm_cmd = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("line in reset", 1'b0, line_out)
        reset_n = 1'b1;
        foreach (rows[i]) begin
            {cfg.src, cfg.invert, cfg.user_value, exp_cmd, frm_cmd} = rows[i][7:1];
            repeat (8) @(negedge clk);
            `CHK("line level", rows[i][0], line_out)
        end
        timer_case(LOTU_ACT_RISE, 1'b1, 1'b0, 1);
        timer_case(LOTU_ACT_FALL, 1'b1, 1'b1, 1);
        timer_case(LOTU_ACT_RISE, 1'b1, 1'b1, 0);
        timer_case(LOTU_ACT_HIGH, 1'b1, 1'b0, 2);
        timer_case(LOTU_ACT_LOW, 1'b1, 1'b1, 2);
        timer_case(LOTU_ACT_RISE, 1'b0, 1'b0, 0);
        // zero duration: the delay runs out and no pulse follows
        cfg.duration_us = 26'h0;
        timer_case(LOTU_ACT_RISE, 1'b1, 1'b0, 0);
        // glitch shorter than the debounce must not reach the line
        cfg.src = LOTU_SRC_EXPOSURE;
        cfg.debounce_us = 16'h2;
        exp_cmd = 1'b0;
        repeat (500) @(negedge clk);
        exp_cmd = 1'b1;
        repeat (50) @(negedge clk);
        exp_cmd = 1'b0;
        hi = 1'b0;
        repeat (400) begin
            @(negedge clk);
            hi = hi | (line_out !== 1'b0);
        end
        `CHK("glitch filtered", 1'b0, hi)
        exp_cmd = 1'b1;
        repeat (400) @(negedge clk);
        `CHK("stable passed", 1'b1, line_out)
        reset_n = 1'b0;
        #1;
        `CHK("line mid reset", 1'b0, line_out)
        results();
    end
endmodule
